/* File: design/sss_params.svh */
/*
 Constants of the sleep state sequencer: register offsets, field positions,
 reset values, sleep type codes and step timing.
 Assumes a 125 MHz clock and a 32-bit Avalon-MM slave with byte addresses.
*/
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SSS_OFS_CTRL      5'h00
`define SSS_OFS_STATUS    5'h04
`define SSS_OFS_WAKE_EN   5'h08
`define SSS_OFS_SYSTEM_MANAGEMENT_COMMAND_PORT   5'h0c

// ****************************************
// Field positions
// ****************************************
`define SSS_CTRL_EN_BIT   8
`define SSS_STAT_WAKE_BIT 0
`define SSS_STAT_SMI_BIT  1
`define SSS_STAT_BUSY_BIT 8

// ****************************************
// Codes and reset values
// ****************************************
`define SSS_TYPE_S2       3'h2
`define SSS_TYPE_S3       3'h3
`define SSS_TYPE_S4       3'h4
`define SSS_TYPE_S5       3'h5
// Arbitrary command value
`define SSS_HIB_REQ       8'h5a
`define SSS_RST_TYPE      3'h0
`define SSS_RST_WAKE_EN   1'b0

// ****************************************
// Timing
// ****************************************
`define SSS_CLK_MHZ       125
`define SSS_STEP_NS       1000
`define SSS_STEP_CYC      ((`SSS_STEP_NS * `SSS_CLK_MHZ + 999) / 1000)

`endif

/* File: design/sss_pkg.sv */
/*
 Types of the sleep state sequencer: sequencer states and sleep kinds.
 Assumes nothing of its surroundings.
*/
package sss_pkg;
   typedef enum logic [3:0] {
      ST_WORK    = 4'h0,
      ST_REFRESH = 4'h1,
      ST_ISOLATE = 4'h2,
      ST_CLKSTOP = 4'h3,
      ST_PWROFF  = 4'h4,
      ST_SLEEP   = 4'h5,
      ST_PWRON   = 4'h6,
      ST_CLKON   = 4'h7,
      ST_RELEASE = 4'h8
   } sss_state_t;

   typedef enum logic [1:0] {
      K_NONE = 2'h0,
      K_S2   = 2'h1,
      K_S3   = 2'h2,
      K_OFF  = 2'h3
   } sss_kind_t;
endpackage : sss_pkg

/* File: design/sss_sequencer.sv */
/*
 Sleep state sequencer: Avalon-MM register slave plus the power sequence for
 the S2, S3, S4 and S5 states.
 Assumes wake and power button pins are asynchronous, and that the clock
 and power outputs drive external clock and supply control.
*/
// Implementation choices: register access over Avalon-MM and the placing of the registers.
// Overview of operation
// - Entering S2 stops all system clocks; only the real-time clock runs.
// - Entering S2 puts memory into self-refresh so its contents survive.
// - Entering S2 removes power from processor and cache.
// - S2 wake resets the processor while core logic and memory keep context.
// - During S2 chipset configuration and memory contents are kept.
// - Entering S3 puts memory into a low-power self-refresh condition.
// - In S3 memory devices isolate before power is removed.
// - In S3 only memory-sustaining devices stay powered.
// - S3 wake restores power and resets most devices.
// - In S4 all devices lose power.
// - Host-initiated S4 through sleep type write is always supported.
// - S5 keeps no context but a power button press still wakes.
// - S4 and S5 follow the identical hardware sequence.
// - The sequence starts on the write that sets type and enable.
// - Wake status is set when an enabled wake event occurs asleep.
`timescale 1ns/100ps
`include "sss_params.svh"

module sss_sequencer (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        wakeEventPin,
   input  wire logic        pwrButtonPin,
   output logic             sysClkEn,
   output logic             memSelfRefresh,
   output logic             memIsolate,
   output logic             cpuPwrEn,
   output logic             mainPwrEn,
   output logic             memPwrEn,
   output logic             cpuRstN,
   output logic             coreRstN,
   output logic             smiReq
);
   localparam logic [7:0] STEP_LAST = 8'(`SSS_STEP_CYC - 1);
   localparam int WAKE_MAX = 600;

   sss_pkg::sss_state_t state_ff, nxt_state;
   sss_pkg::sss_kind_t  kind_ff, nxt_kind;
   logic [7:0]  stepCnt_ff, nxt_stepCnt;
   logic [31:0] readData_ff, nxt_readData;
   logic [2:0]  type_ff, nxt_type;
   logic        waitReq_ff, nxt_waitReq;
   logic        wakeEn_ff, nxt_wakeEn;
   logic        wakeSts_ff, nxt_wakeSts;
   logic        smiPend_ff, nxt_smiPend;
   logic        smiReq_ff, nxt_smiReq;
   logic        start_ff, nxt_start;
   logic        clk_ff, nxt_clk, refr_ff, nxt_refr, iso_ff, nxt_iso;
   logic        cpuPwr_ff, nxt_cpuPwr, mainPwr_ff, nxt_mainPwr;
   logic        memPwr_ff, nxt_memPwr, cpuRst_ff, nxt_cpuRst;
   logic        coreRst_ff, nxt_coreRst;
   logic [1:0]  wakeMeta_ff, btnMeta_ff;
   logic        wrTake, stepDone, wakeHit;

   // ****************************************
   // Decode
   // ****************************************
   // S4 and S5 share one kind so their hardware sequence cannot diverge
   function automatic sss_pkg::sss_kind_t kindOf(input logic [2:0] t);
      case (t)
         `SSS_TYPE_S2: kindOf = sss_pkg::K_S2;
         `SSS_TYPE_S3: kindOf = sss_pkg::K_S3;
         `SSS_TYPE_S4: kindOf = sss_pkg::K_OFF;
         `SSS_TYPE_S5: kindOf = sss_pkg::K_OFF;
         default:      kindOf = sss_pkg::K_NONE;
      endcase
   endfunction : kindOf

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wakeMeta_ff <= 2'h0;
         btnMeta_ff  <= 2'h0;
      end else begin
         wakeMeta_ff <= {wakeMeta_ff[0], wakeEventPin};
         btnMeta_ff  <= {btnMeta_ff[0], pwrButtonPin};
      end
   end

   assign wrTake   = avs_write && !waitReq_ff;
   assign stepDone = (stepCnt_ff == STEP_LAST);
   // Power button always wakes, so S5 is never a dead end
   assign wakeHit  = (state_ff == sss_pkg::ST_SLEEP) &&
                     ((wakeMeta_ff[1] && wakeEn_ff) || btnMeta_ff[1]);

   // ****************************************
   // Register slave
   // ****************************************
   always_comb begin
      nxt_waitReq  = !((avs_read || avs_write) && waitReq_ff);
      nxt_readData = readData_ff;
      nxt_type     = type_ff;
      nxt_wakeEn   = wakeEn_ff;
      nxt_wakeSts  = wakeSts_ff;
      nxt_smiPend  = smiPend_ff;
      nxt_smiReq   = 1'b0;
      nxt_start    = 1'b0;
      if (avs_read && waitReq_ff) begin
         nxt_readData = 32'h0;
         case (avs_address)
            `SSS_OFS_CTRL:    nxt_readData[2:0] = type_ff;
            `SSS_OFS_STATUS: begin
               nxt_readData[`SSS_STAT_WAKE_BIT] = wakeSts_ff;
               nxt_readData[`SSS_STAT_SMI_BIT]  = smiPend_ff;
               nxt_readData[7:4]                = state_ff;
               nxt_readData[`SSS_STAT_BUSY_BIT] = (state_ff != sss_pkg::ST_WORK);
            end
            `SSS_OFS_WAKE_EN: nxt_readData[0] = wakeEn_ff;
            default:          nxt_readData = 32'h0;
         endcase
      end
      if (wrTake) begin
         case (avs_address)
            `SSS_OFS_CTRL: begin
               // Type is kept across sleep; no wake path touches it
               if (avs_byteenable[0]) nxt_type = avs_writedata[2:0];
               if (avs_byteenable[1] && avs_writedata[`SSS_CTRL_EN_BIT]) nxt_start = 1'b1;
            end
            `SSS_OFS_STATUS: begin
               if (avs_byteenable[0] && avs_writedata[`SSS_STAT_WAKE_BIT]) nxt_wakeSts = 1'b0;
               if (avs_byteenable[0] && avs_writedata[`SSS_STAT_SMI_BIT]) nxt_smiPend = 1'b0;
            end
            `SSS_OFS_WAKE_EN: if (avs_byteenable[0]) nxt_wakeEn = avs_writedata[0];
            `SSS_OFS_SYSTEM_MANAGEMENT_COMMAND_PORT: begin
               // Firmware takes over and later writes the S4 type itself
               if (avs_byteenable[0] && avs_writedata[7:0] == `SSS_HIB_REQ) begin
                  nxt_smiPend = 1'b1;
                  nxt_smiReq  = 1'b1;
               end
            end
            default: nxt_type = type_ff;
         endcase
      end
      // Set wins over a clear in the same cycle
      if (wakeHit) nxt_wakeSts = 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         waitReq_ff  <= 1'b1;
         readData_ff <= 32'h0;
         type_ff     <= `SSS_RST_TYPE;
         wakeEn_ff   <= `SSS_RST_WAKE_EN;
         wakeSts_ff  <= 1'b0;
         smiPend_ff  <= 1'b0;
         smiReq_ff   <= 1'b0;
         start_ff    <= 1'b0;
      end else begin
         waitReq_ff  <= nxt_waitReq;
         readData_ff <= nxt_readData;
         type_ff     <= nxt_type;
         wakeEn_ff   <= nxt_wakeEn;
         wakeSts_ff  <= nxt_wakeSts;
         smiPend_ff  <= nxt_smiPend;
         smiReq_ff   <= nxt_smiReq;
         start_ff    <= nxt_start;
      end
   end

   // ****************************************
   // Power sequencer
   // ****************************************
   always_comb begin
      nxt_state   = state_ff;
      nxt_kind    = kind_ff;
      nxt_stepCnt = stepDone ? 8'h00 : stepCnt_ff + 8'h01;
      nxt_clk     = clk_ff;
      nxt_refr    = refr_ff;
      nxt_iso     = iso_ff;
      nxt_cpuPwr  = cpuPwr_ff;
      nxt_mainPwr = mainPwr_ff;
      nxt_memPwr  = memPwr_ff;
      nxt_cpuRst  = cpuRst_ff;
      nxt_coreRst = coreRst_ff;
      case (state_ff)
         sss_pkg::ST_WORK: begin
            nxt_stepCnt = 8'h00;
            {nxt_clk, nxt_cpuPwr, nxt_mainPwr, nxt_memPwr} = 4'hf;
            {nxt_cpuRst, nxt_coreRst, nxt_refr, nxt_iso}   = 4'hc;
            // Unknown type codes are ignored
            if (start_ff && kindOf(type_ff) != sss_pkg::K_NONE) begin
               nxt_kind  = kindOf(type_ff);
               nxt_state = (kindOf(type_ff) == sss_pkg::K_OFF) ?
                           sss_pkg::ST_CLKSTOP : sss_pkg::ST_REFRESH;
            end
         end
         sss_pkg::ST_REFRESH: begin
            nxt_refr = 1'b1;
            if (stepDone) nxt_state = (kind_ff == sss_pkg::K_S3) ?
                                      sss_pkg::ST_ISOLATE : sss_pkg::ST_CLKSTOP;
         end
         sss_pkg::ST_ISOLATE: begin
            nxt_iso = 1'b1;
            if (stepDone) nxt_state = sss_pkg::ST_CLKSTOP;
         end
         sss_pkg::ST_CLKSTOP: begin
            nxt_clk = 1'b0;
            if (stepDone) nxt_state = sss_pkg::ST_PWROFF;
         end
         sss_pkg::ST_PWROFF: begin
            // Resets fall with power so nothing wakes half-initialised
            nxt_cpuPwr = 1'b0;
            nxt_cpuRst = 1'b0;
            if (kind_ff != sss_pkg::K_S2) begin
               nxt_mainPwr = 1'b0;
               nxt_coreRst = 1'b0;
            end
            if (kind_ff == sss_pkg::K_OFF) nxt_memPwr = 1'b0;
            if (stepDone) nxt_state = sss_pkg::ST_SLEEP;
         end
         sss_pkg::ST_SLEEP: begin
            nxt_stepCnt = 8'h00;
            if (wakeHit) nxt_state = sss_pkg::ST_PWRON;
         end
         sss_pkg::ST_PWRON: begin
            {nxt_cpuPwr, nxt_mainPwr, nxt_memPwr} = 3'h7;
            if (stepDone) nxt_state = sss_pkg::ST_CLKON;
         end
         sss_pkg::ST_CLKON: begin
            nxt_clk = 1'b1;
            if (stepDone) nxt_state = sss_pkg::ST_RELEASE;
         end
         sss_pkg::ST_RELEASE: begin
            // Core leaves reset first; the processor starts last, at boot vector
            nxt_coreRst = 1'b1;
            nxt_refr    = 1'b0;
            nxt_iso     = 1'b0;
            if (stepDone) nxt_state = sss_pkg::ST_WORK;
         end
         default: nxt_state = sss_pkg::ST_WORK;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= sss_pkg::ST_WORK;
         kind_ff    <= sss_pkg::K_NONE;
         stepCnt_ff <= 8'h00;
         clk_ff     <= 1'b1;
         refr_ff    <= 1'b0;
         iso_ff     <= 1'b0;
         cpuPwr_ff  <= 1'b1;
         mainPwr_ff <= 1'b1;
         memPwr_ff  <= 1'b1;
         cpuRst_ff  <= 1'b1;
         coreRst_ff <= 1'b1;
      end else begin
         state_ff   <= nxt_state;
         kind_ff    <= nxt_kind;
         stepCnt_ff <= nxt_stepCnt;
         clk_ff     <= nxt_clk;
         refr_ff    <= nxt_refr;
         iso_ff     <= nxt_iso;
         cpuPwr_ff  <= nxt_cpuPwr;
         mainPwr_ff <= nxt_mainPwr;
         memPwr_ff  <= nxt_memPwr;
         cpuRst_ff  <= nxt_cpuRst;
         coreRst_ff <= nxt_coreRst;
      end
   end

   assign avs_readdata    = readData_ff;
   assign avs_waitrequest = waitReq_ff;
   assign sysClkEn        = clk_ff;
   assign memSelfRefresh  = refr_ff;
   assign memIsolate      = iso_ff;
   assign cpuPwrEn        = cpuPwr_ff;
   assign mainPwrEn       = mainPwr_ff;
   assign memPwrEn        = memPwr_ff;
   assign cpuRstN         = cpuRst_ff;
   assign coreRstN        = coreRst_ff;
   assign smiReq          = smiReq_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_SLEEP_CLK_OFF: assert property (state_ff == sss_pkg::ST_SLEEP |-> !clk_ff)
      else $error("Clock running while asleep");
   AST_SLEEP_REFRESH: assert property (state_ff == sss_pkg::ST_SLEEP &&
      kind_ff != sss_pkg::K_OFF |-> refr_ff && memPwr_ff)
      else $error("Memory not in self-refresh while asleep");
   AST_SLEEP_CPU_OFF: assert property (state_ff == sss_pkg::ST_SLEEP |->
      !cpuPwr_ff && !cpuRst_ff)
      else $error("Processor powered while asleep");
   AST_S2_CORE_KEPT: assert property (kind_ff == sss_pkg::K_S2 &&
      state_ff != sss_pkg::ST_WORK |-> coreRst_ff && mainPwr_ff)
      else $error("Core context lost in S2");
   AST_S3_ISO_FIRST: assert property ($fell(mainPwr_ff) && kind_ff == sss_pkg::K_S3 |->
      iso_ff)
      else $error("Power removed before isolation");
   AST_S3_POWER: assert property (state_ff == sss_pkg::ST_SLEEP &&
      kind_ff == sss_pkg::K_S3 |-> !mainPwr_ff && memPwr_ff && refr_ff)
      else $error("Wrong supplies in S3");
   AST_OFF_ALL: assert property (state_ff == sss_pkg::ST_SLEEP &&
      kind_ff == sss_pkg::K_OFF |-> !memPwr_ff && !mainPwr_ff && !coreRst_ff)
      else $error("Supply left on in S4 or S5");
   AST_START: assert property (state_ff == sss_pkg::ST_WORK && start_ff &&
      kindOf(type_ff) != sss_pkg::K_NONE |=> state_ff != sss_pkg::ST_WORK)
      else $error("Sleep write did not start sequence");
   AST_WAKE_STS: assert property (wakeHit |=> wakeSts_ff)
      else $error("Wake status not set");
   AST_WAKE_RESET: assert property (wakeHit |=> !cpuRst_ff[*2] ##[1:WAKE_MAX] cpuRst_ff)
      else $error("Processor not reset then released on wake");
   AST_TYPE_KEPT: assert property (state_ff != sss_pkg::ST_WORK && !wrTake |=>
      $stable(type_ff))
      else $error("Sleep type changed while asleep");
   COV_S2: cover property (state_ff == sss_pkg::ST_SLEEP && kind_ff == sss_pkg::K_S2);
   COV_S3: cover property (state_ff == sss_pkg::ST_SLEEP && kind_ff == sss_pkg::K_S3);
   COV_OFF_WAKE: cover property (kind_ff == sss_pkg::K_OFF && wakeHit);
   COV_SMI: cover property (smiReq_ff);
endmodule : sss_sequencer

/* File: verif/sss_platform_model.sv */
/*
 Far-side model of memory and supplies behind the sleep state sequencer.
 Assumes the sequencer's clock, refresh, isolation and supply outputs.
*/
`timescale 1ns/100ps

module sss_platform_model (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic sysClkEn,
   input  wire logic memSelfRefresh,
   input  wire logic memIsolate,
   input  wire logic mainPwrEn,
   input  wire logic memPwrEn,
   input  wire logic memLoad,
   output logic      memIntact
);
   logic memIntact_ff;
   logic nxt_memIntact;

   // ****************************************
   // Memory retention
   // ****************************************
   // Contents are lost for good once lost; only a reload restores them
   always_comb begin
      nxt_memIntact = memIntact_ff | memLoad;
      if (!memPwrEn) begin
         nxt_memIntact = 1'b0;
      end
      if (!sysClkEn && !memSelfRefresh && memPwrEn) begin
         nxt_memIntact = 1'b0;
      end
      if (!mainPwrEn && memPwrEn && !memIsolate) begin
         nxt_memIntact = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         memIntact_ff <= 1'b0;
      end else begin
         memIntact_ff <= nxt_memIntact;
      end
   end

   assign memIntact = memIntact_ff;
endmodule : sss_platform_model

/* File: verif/sss_sequencer_tb.sv */
/*
 Self-checking bench of the sleep state sequencer: register bus, every
 sleep type, wake sources and the hibernate command.
 Assumes sss_params.svh on the include path and the platform model.
*/
`timescale 1ns/100ps
`include "sss_params.svh"

module sss_sequencer_tb;
   logic        mclk;
   logic        rst_n;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        wakeEventPin;
   logic        pwrButtonPin;
   logic        sysClkEn;
   logic        memSelfRefresh;
   logic        memIsolate;
   logic        cpuPwrEn;
   logic        mainPwrEn;
   logic        memPwrEn;
   logic        cpuRstN;
   logic        coreRstN;
   logic        smiReq;
   logic        memLoad;
   logic        memIntact;
   logic [7:0]  outs;
   logic [31:0] q;
   logic [31:0] d;
   int          err_count = 0;
   int          checks_done = 0;
   int          cycCount = 0;
   int          smiCount = 0;
   int          seed = 15093;
   logic [2:0]  typList [4] = '{`SSS_TYPE_S2, `SSS_TYPE_S3, `SSS_TYPE_S4, `SSS_TYPE_S5};
   logic [2:0]  badList [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
   localparam logic [31:0] START = 32'h1 << `SSS_CTRL_EN_BIT;

   assign outs = {sysClkEn, memSelfRefresh, memIsolate, cpuPwrEn,
                  mainPwrEn, memPwrEn, cpuRstN, coreRstN};

   sss_sequencer sss_sequencer_i (
      .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .wakeEventPin(wakeEventPin), .pwrButtonPin(pwrButtonPin), .sysClkEn(sysClkEn),
      .memSelfRefresh(memSelfRefresh), .memIsolate(memIsolate), .cpuPwrEn(cpuPwrEn),
      .mainPwrEn(mainPwrEn), .memPwrEn(memPwrEn), .cpuRstN(cpuRstN),
      .coreRstN(coreRstN), .smiReq(smiReq));

   sss_platform_model sss_platform_model_i (
      .mclk(mclk), .rst_n(rst_n), .sysClkEn(sysClkEn), .memSelfRefresh(memSelfRefresh),
      .memIsolate(memIsolate), .mainPwrEn(mainPwrEn), .memPwrEn(memPwrEn),
      .memLoad(memLoad), .memIntact(memIntact));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      if (err_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   // Generous ceiling: four sleep rounds take some 3000 cycles
   always @(posedge mclk) begin
      cycCount <= cycCount + 1;
      if (smiReq === 1'b1) begin
         smiCount <= smiCount + 1;
      end
      if (cycCount == 30000) begin
         err_count++;
         end_sim();
      end
   end

   // Sleep-state output pattern, worked out from the step list
   function automatic logic [7:0] expOut(input logic [2:0] t);
      if (t == `SSS_TYPE_S2) begin
         return 8'h4d;
      end else if (t == `SSS_TYPE_S3) begin
         return 8'h64;
      end
      return 8'h00;
   endfunction : expOut

   // ****************************************
   // Bus and pin drivers
   // ****************************************
   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= !wr;
      // Only the bench timeout ends a wait that never sees waitrequest low
      do begin
         @(posedge mclk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic pulsePin(input logic btn, input int hold);
      if (btn) pwrButtonPin <= 1'b1;
      else wakeEventPin <= 1'b1;
      repeat (hold) @(posedge mclk);
      pwrButtonPin <= 1'b0;
      wakeEventPin <= 1'b0;
      repeat (10) @(posedge mclk);
   endtask : pulsePin

   // ****************************************
   // One full sleep and wake round
   // ****************************************
   task automatic sleepRound(input logic [2:0] t);
      int n;
      logic [2:0] expType;
      expType = t;
      d = $random(seed);
      d[0] = (t == `SSS_TYPE_S2);
      bus(1'b1, `SSS_OFS_WAKE_EN, d, q);
      // Host cache flush leaves memory holding the live data
      memLoad <= 1'b1;
      @(posedge mclk);
      memLoad <= 1'b0;
      bus(1'b1, `SSS_OFS_CTRL, START | t, q);
      bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
      chk(q[8:4], (t < `SSS_TYPE_S4) ? 5'h11 : 5'h13);
      if (t == `SSS_TYPE_S5) begin
         bus(1'b1, `SSS_OFS_CTRL, START | `SSS_TYPE_S2, q);
         expType = `SSS_TYPE_S2;
      end
      n = 0;
      do begin
         bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
         n++;
      end while (q[7:4] !== 4'h5 && n < 400);
      chk(outs, expOut(t));
      if (t != `SSS_TYPE_S2) begin
         pulsePin(1'b0, 5);
         bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
         chk(q[7:0], 8'h50);
      end
      pulsePin(t != `SSS_TYPE_S2, 3 + ($random(seed) & 3));
      n = 0;
      while (cpuRstN !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      chk(outs, 8'h9f);
      chk(memIntact, t < `SSS_TYPE_S4);
      // Boot firmware restores its setup and rebuilds memory after every wake
      memLoad <= 1'b1;
      @(posedge mclk);
      memLoad <= 1'b0;
      bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
      chk(q[8:0], 9'h001);
      bus(1'b1, `SSS_OFS_STATUS, 32'h1, q);
      bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
      chk(q[0], 1'b0);
      bus(1'b0, `SSS_OFS_CTRL, 32'h0, q);
      chk(q[8:0], {6'h00, expType});
   endtask : sleepRound

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_n         = 1'b0;
      avs_address   = 5'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      wakeEventPin  = 1'b0;
      pwrButtonPin  = 1'b0;
      memLoad       = 1'b0;
      repeat (3) @(posedge mclk);
      chk({avs_waitrequest, smiReq, outs}, 10'h29f);
      rst_n <= 1'b1;
      @(posedge mclk);
      bus(1'b0, `SSS_OFS_CTRL, 32'h0, q);
      chk(q, {29'h0, `SSS_RST_TYPE});
      bus(1'b0, `SSS_OFS_WAKE_EN, 32'h0, q);
      chk(q[0], `SSS_RST_WAKE_EN);
      bus(1'b0, 5'h10, 32'h0, q);
      chk(q, 32'h0);
      // Wake source while awake must not flag a wake
      bus(1'b1, `SSS_OFS_WAKE_EN, 32'h1, q);
      pulsePin(1'b0, 5);
      bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
      chk(q[8:0], 9'h000);
      foreach (badList[i]) begin
         bus(1'b1, `SSS_OFS_CTRL, START | badList[i], q);
         repeat (4) @(posedge mclk);
         bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
         chk(q[8:4], 5'h00);
      end
      // Start bit on a disabled lane must not start, type lane still lands
      avs_byteenable <= 4'h1;
      bus(1'b1, `SSS_OFS_CTRL, START | `SSS_TYPE_S2, q);
      avs_byteenable <= 4'hf;
      bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
      chk(q[8:4], 5'h00);
      bus(1'b0, `SSS_OFS_CTRL, 32'h0, q);
      chk(q[8:0], {6'h00, `SSS_TYPE_S2});
      d = $random(seed);
      if (d[7:0] == `SSS_HIB_REQ) d[7:0] = 8'h00;
      bus(1'b1, `SSS_OFS_SYSTEM_MANAGEMENT_COMMAND_PORT, d, q);
      bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
      chk({smiCount[1:0], q[1]}, 3'h0);
      bus(1'b1, `SSS_OFS_SYSTEM_MANAGEMENT_COMMAND_PORT, {24'h0, `SSS_HIB_REQ}, q);
      bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
      chk({smiCount[1:0], q[1]}, 3'h3);
      bus(1'b1, `SSS_OFS_STATUS, 32'h2, q);
      bus(1'b0, `SSS_OFS_STATUS, 32'h0, q);
      chk(q[1], 1'b0);
      foreach (typList[i]) sleepRound(typList[i]);
      end_sim();
   end
endmodule : sss_sequencer_tb
